//--- rtl/atten_position_ctrl.sv
// Position tracking and limit checking for a stepper-driven rotary vane
// attenuator. Assumes synchronous sensor inputs and a one-master register port.
//
// Summary of operation
// - Seek-max without high attenuation support ends in limit-hit fault.
// - Raw mode without high attenuation support: in-range negative target ends in limit-hit fault.
// - Unreliable index: flag it, keep own count as reference, stay usable; with index check on, as after reset, a missed index aborts the move.
// - Slow index: wait for it to settle, then flag slow settling.
// - The 0 to 60 dB span is exactly 8574 steps.
// - A 90 degree turn is exactly 8750 steps.
// - Long-cable option stretches the step period by 30 percent.
// - Slow variant stretches the step period by 20 percent.
// - Warn when upper flag sits beyond its recommended place; the check needs the counter below -240 steps, which no legal move reaches.
// - Warn when lower flag sits below its recommended place.
// - Either limit flag during a move raises limit-hit fault.
// - Raw targets only from -150 to 8574 steps.
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module atten_position_ctrl #(
  parameter int STEP_PERIOD = atten_pos_pkg::STEP_CYCLES,
  parameter int SETTLE_MAX = atten_pos_pkg::SETTLE_MAX_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire logic upper_limit,
  input wire logic lower_limit,
  input wire logic index_pulse,
  output logic step_pulse,
  output logic step_dir,
  output logic busy,
  output logic irq
);

  atten_pos_pkg::pos_state_s cur;
  atten_pos_pkg::pos_state_s nxt;
  // Helpers below are pure decode of the current state and the port inputs;
  // only cur and busy hold state.
  logic [31:0] period;
  logic [7:0] events;
  logic [7:0] w1c;
  logic signed [15:0] req;
  logic req_bad;
  logic req_lim;
  logic next_up;
  logic signed [15:0] next_pos;
  logic [8:0] next_phase;

  // Step period stretched by variant and cable options. The percent scaling is
  // integer, so a stretched period rounds down by less than one clock cycle,
  // far below what a full-range transition time can resolve.
  always_comb
  begin
    period = 32'(STEP_PERIOD * (atten_pos_pkg::PCT_BASE
      + (cur.ctrl[atten_pos_pkg::CTRL_SLOW_VARIANT] ? atten_pos_pkg::PCT_SLOW_VARIANT : 0)
      + (cur.ctrl[atten_pos_pkg::CTRL_LONG_CABLE] ? atten_pos_pkg::PCT_LONG_CABLE : 0))
      / atten_pos_pkg::PCT_BASE);
  end

  // Target validation for a new move request. Seek-max is judged first since it
  // replaces the written target; the raw range test comes before the negative
  // test so an out-of-range negative target reports a range error, not a limit.
  always_comb
  begin
    req = $signed(reg_wdata[15:0]);
    req_bad = 1'b0;
    req_lim = 1'b0;
    if (reg_wdata[atten_pos_pkg::CTRL_SEEK_MAX])
    begin
      req = atten_pos_pkg::HIGH_ATTEN_STEPS;
      req_lim = !reg_wdata[atten_pos_pkg::CTRL_HIGH_ATTEN_OK];
    end
    else
    begin
      req = cur.target;
      if (reg_wdata[atten_pos_pkg::CTRL_RAW_STEPS])
      begin
        if (cur.target < atten_pos_pkg::RAW_MIN_STEPS
          || cur.target > atten_pos_pkg::SPAN_STEPS)
          req_bad = 1'b1;
        else if (cur.target < 16'sd0 && !reg_wdata[atten_pos_pkg::CTRL_HIGH_ATTEN_OK])
          req_lim = 1'b1;
      end
      else if (cur.target < 16'sd0 || cur.target > atten_pos_pkg::SPAN_STEPS)
        req_bad = 1'b1;
    end
  end

  // Counter and index phase after one step in the current direction.
  // The phase wraps at the index pitch both ways, so the expected index
  // place stays right however often the direction reverses.
  always_comb
  begin
    next_up = cur.target > cur.pos;
    next_pos = next_up ? cur.pos + 16'sd1 : cur.pos - 16'sd1;
    if (next_up)
      next_phase = (cur.phase == atten_pos_pkg::INDEX_PITCH - 9'd1) ? 9'd0
        : cur.phase + 9'd1;
    else
      next_phase = (cur.phase == 9'd0) ? atten_pos_pkg::INDEX_PITCH - 9'd1
        : cur.phase - 9'd1;
  end

  always_comb
  begin
    nxt = cur;
    events = 8'h00;
    w1c = 8'h00;
    nxt.step_pulse = 1'b0;
    nxt.rdata = 32'h0000_0000;

    // Read data live for one cycle only and are zero otherwise, so several
    // slaves may share the return path by a plain OR.
    if (reg_read)
    begin
      case (reg_addr)
        atten_pos_pkg::ADDR_CTRL: nxt.rdata = {24'h00_0000, cur.ctrl};
        atten_pos_pkg::ADDR_TARGET: nxt.rdata = {{16{cur.target[15]}}, cur.target};
        atten_pos_pkg::ADDR_POSITION: nxt.rdata = {{16{cur.pos[15]}}, cur.pos};
        atten_pos_pkg::ADDR_STATUS: nxt.rdata = {24'h00_0000, cur.status};
        atten_pos_pkg::ADDR_MASK: nxt.rdata = {24'h00_0000, cur.mask};
        atten_pos_pkg::ADDR_STATE: nxt.rdata = {13'h0000, cur.phase, 3'h0,
          index_pulse, lower_limit, upper_limit, cur.st};
        default: nxt.rdata = 32'h0000_0000;
      endcase
    end

    // A target write while busy is dropped so a running move cannot change
    // its end point; options written with GO take effect at once.
    if (reg_write)
    begin
      case (reg_addr)
        atten_pos_pkg::ADDR_CTRL:
        begin
          nxt.ctrl = reg_wdata[7:0] & ~8'h41;
          if (reg_wdata[atten_pos_pkg::CTRL_GO] && cur.st == atten_pos_pkg::ST_IDLE)
          begin
            if (req_lim)
              events[atten_pos_pkg::ST_LIMIT_HIT] = 1'b1;
            else if (req_bad)
              events[atten_pos_pkg::ST_RANGE_ERR] = 1'b1;
            else
            begin
              nxt.target = req;
              nxt.travelled = 16'h0000;
              nxt.st = atten_pos_pkg::ST_CHECK;
            end
          end
        end
        atten_pos_pkg::ADDR_TARGET:
          if (cur.st == atten_pos_pkg::ST_IDLE)
            nxt.target = $signed(reg_wdata[15:0]);
        atten_pos_pkg::ADDR_STATUS: w1c = reg_wdata[7:0];
        atten_pos_pkg::ADDR_MASK: nxt.mask = reg_wdata[7:0];
        default: ;
      endcase
    end

    // Sensor self-test, watched continuously from the counter.
    // Limitation: a legal move never passes -240 steps, so the upper warning
    // can only appear if the counter has been carried beyond the raw minimum.
    if (!upper_limit
      && cur.pos < -(atten_pos_pkg::UPPER_FLAG_STEPS + atten_pos_pkg::FLAG_TOLERANCE))
      events[atten_pos_pkg::ST_UPPER_WARN] = 1'b1;
    if (lower_limit
      && cur.pos < atten_pos_pkg::SPAN_STEPS + atten_pos_pkg::LOWER_FLAG_STEPS
        - atten_pos_pkg::FLAG_TOLERANCE)
      events[atten_pos_pkg::ST_LOWER_WARN] = 1'b1;

    case (cur.st)
      atten_pos_pkg::ST_IDLE: ;
      atten_pos_pkg::ST_CHECK:
      begin
        // Checked once per step; the flags seen here still show the shaft
        // before the last step, so they are looked at again at launch.
        if (cur.pos == cur.target)
        begin
          events[atten_pos_pkg::ST_DONE] = 1'b1;
          nxt.st = atten_pos_pkg::ST_IDLE;
        end
        else if (upper_limit || lower_limit
          || cur.travelled >= 16'(atten_pos_pkg::QUARTER_TURN_STEPS))
        begin
          events[atten_pos_pkg::ST_LIMIT_HIT] = 1'b1;
          nxt.st = atten_pos_pkg::ST_IDLE;
        end
        else
        begin
          nxt.tick = 32'h0000_0000;
          nxt.step_dir = next_up;
          nxt.st = atten_pos_pkg::ST_WAIT;
        end
      end
      atten_pos_pkg::ST_WAIT:
      begin
        // An index seen away from its expected place means the sensor is suspect.
        if (index_pulse && cur.phase != 9'd0 && cur.tick == 32'h0000_0000)
          events[atten_pos_pkg::ST_INDEX_INVALID] = 1'b1;
        if (cur.tick + 32'h0000_0001 >= period && (upper_limit || lower_limit))
        begin
          // The flags answer one cycle after a step, so the step that would
          // carry the shaft further into a flag is withheld here.
          events[atten_pos_pkg::ST_LIMIT_HIT] = 1'b1;
          nxt.st = atten_pos_pkg::ST_IDLE;
        end
        else if (cur.tick + 32'h0000_0001 >= period)
        begin
          nxt.step_pulse = 1'b1;
          nxt.pos = next_pos;
          nxt.phase = next_phase;
          nxt.travelled = cur.travelled + 16'h0001;
          nxt.settle = 32'h0000_0000;
          nxt.st = (next_phase == 9'd0) ? atten_pos_pkg::ST_SETTLE
            : atten_pos_pkg::ST_CHECK;
        end
        else
          nxt.tick = cur.tick + 32'h0000_0001;
      end
      atten_pos_pkg::ST_SETTLE:
      begin
        // Move is held here until the index answers or the wait runs out.
        // A slow index costs only this wait; the move then resumes from the
        // same place, so calibration is not disturbed.
        if (index_pulse)
        begin
          if (cur.settle >= 32'(atten_pos_pkg::SETTLE_REC_CYCLES))
            events[atten_pos_pkg::ST_INDEX_SLOW] = 1'b1;
          nxt.st = atten_pos_pkg::ST_CHECK;
        end
        else if (cur.settle + 32'h0000_0001 >= 32'(SETTLE_MAX))
        begin
          // Own count stands in for the reference when checking is off.
          events[atten_pos_pkg::ST_INDEX_INVALID] = 1'b1;
          if (cur.ctrl[atten_pos_pkg::CTRL_INDEX_CHECK])
          begin
            events[atten_pos_pkg::ST_INDEX_MISS] = 1'b1;
            nxt.st = atten_pos_pkg::ST_IDLE;
          end
          else
            nxt.st = atten_pos_pkg::ST_CHECK;
        end
        else
          nxt.settle = cur.settle + 32'h0000_0001;
      end
      default: nxt.st = atten_pos_pkg::ST_IDLE;
    endcase

    // A new event wins over a clear in the same cycle, so an event is never
    // lost to a clear that software issued before it could see the event.
    nxt.status = (cur.status & ~w1c) | events;
    nxt.irq = |(nxt.status & nxt.mask);
  end

  // Busy is registered from the next state so it rises in the same cycle as
  // the first check state and falls with the return to idle.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cur.st <= atten_pos_pkg::ST_IDLE;
      cur.ctrl <= atten_pos_pkg::CTRL_RESET;
      cur.target <= 16'sd0;
      cur.pos <= 16'sd0;
      cur.phase <= 9'd0;
      cur.travelled <= 16'h0000;
      cur.status <= 8'h00;
      cur.mask <= 8'h00;
      cur.tick <= 32'h0000_0000;
      cur.settle <= 32'h0000_0000;
      cur.rdata <= 32'h0000_0000;
      cur.step_pulse <= 1'b0;
      cur.step_dir <= 1'b0;
      cur.irq <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      cur <= nxt;
      busy <= nxt.st != atten_pos_pkg::ST_IDLE;
    end
  end

  // Every output is a bit of the registered state, so none carries a glitch
  // from the next-state logic.
  assign reg_rdata = cur.rdata;
  assign step_pulse = cur.step_pulse;
  assign step_dir = cur.step_dir;
  assign irq = cur.irq;

endmodule : atten_position_ctrl

`default_nettype wire

//--- rtl/atten_pos_pkg.sv
// Package for the attenuator position block: register map, field layout,
// step geometry, timing constants and the state carrier.
// Assumes a 100 MHz system clock and a simple strobe register port.
package atten_pos_pkg;

  // Register byte addresses.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TARGET = 8'h04;
  localparam logic [7:0] ADDR_POSITION = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_MASK = 8'h10;
  localparam logic [7:0] ADDR_STATE = 8'h14;

  // Control register fields.
  localparam int CTRL_GO = 0;
  localparam int CTRL_RAW_STEPS = 1;
  localparam int CTRL_LONG_CABLE = 2;
  localparam int CTRL_SLOW_VARIANT = 3;
  localparam int CTRL_HIGH_ATTEN_OK = 4;
  localparam int CTRL_INDEX_CHECK = 5;
  localparam int CTRL_SEEK_MAX = 6;
  localparam logic [7:0] CTRL_RESET = 8'h20;

  // Status, and mask, fields.
  localparam int ST_DONE = 0;
  localparam int ST_LIMIT_HIT = 1;
  localparam int ST_INDEX_MISS = 2;
  localparam int ST_RANGE_ERR = 3;
  localparam int ST_UPPER_WARN = 4;
  localparam int ST_LOWER_WARN = 5;
  localparam int ST_INDEX_INVALID = 6;
  localparam int ST_INDEX_SLOW = 7;

  // Step geometry, counted from the index reference at 60 dB.
  localparam logic signed [15:0] SPAN_STEPS = 16'sd8574;
  localparam logic signed [15:0] QUARTER_TURN_STEPS = 16'sd8750;
  localparam logic signed [15:0] RAW_MIN_STEPS = -16'sd150;
  localparam logic signed [15:0] HIGH_ATTEN_STEPS = -16'sd150;
  localparam logic signed [15:0] UPPER_FLAG_STEPS = 16'sd220;
  localparam logic signed [15:0] LOWER_FLAG_STEPS = 16'sd200;
  localparam logic signed [15:0] FLAG_TOLERANCE = 16'sd20;
  localparam logic [8:0] INDEX_PITCH = 9'd500;

  // Step rate scaling in percent.
  localparam int PCT_BASE = 100;
  localparam int PCT_SLOW_VARIANT = 20;
  localparam int PCT_LONG_CABLE = 30;

  // Timing.
  localparam int CLK_PERIOD_NS = 10;
  localparam int FULL_RANGE_US = 1100000;
  localparam int STEP_CYCLES = (FULL_RANGE_US * 1000 / CLK_PERIOD_NS) / 8574;
  localparam int SETTLE_REC_US = 20;
  localparam int SETTLE_REC_CYCLES = SETTLE_REC_US * 1000 / CLK_PERIOD_NS;
  localparam int SETTLE_MAX_US = 200;
  localparam int SETTLE_MAX_CYCLES = SETTLE_MAX_US * 1000 / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CHECK = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_SETTLE = 4'b1000
  } move_state_e;

  typedef struct packed {
    move_state_e st;
    logic [7:0] ctrl;
    logic signed [15:0] target;
    logic signed [15:0] pos;
    logic [8:0] phase;
    logic [15:0] travelled;
    logic [7:0] status;
    logic [7:0] mask;
    logic [31:0] tick;
    logic [31:0] settle;
    logic [31:0] rdata;
    logic step_pulse;
    logic step_dir;
    logic irq;
  } pos_state_s;

endpackage : atten_pos_pkg

//--- sim/atten_pos_props.sv
// Checker for the attenuator position block.
// Assumes STEP_PERIOD of 10 or more and one clock domain.
`timescale 1ns/10ps
`default_nettype none
module atten_pos_props (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic upper_limit,
  input wire logic lower_limit,
  input wire logic index_pulse,
  input wire logic step_pulse,
  input wire logic step_dir,
  input wire logic busy,
  input wire logic irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  step_gap_a: assert property (step_pulse |=> !step_pulse [*8])
    else $error("steps too close");
  step_busy_a: assert property (step_pulse |-> busy)
    else $error("step while idle");
  limit_stop_a: assert property (busy && (upper_limit || lower_limit) |-> !step_pulse)
    else $error("step past a limit flag");
  dir_hold_a: assert property (busy && $past(busy) && $past(busy, 2) |-> $stable(step_dir))
    else $error("direction changed in a move");
  busy_cause_a: assert property ($rose(busy) |-> $past(reg_write) || $past(reg_write, 2))
    else $error("move began unasked");
  rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  irq_mask_a: assert property (reg_write && reg_addr == atten_pos_pkg::ADDR_MASK
    && reg_wdata == 32'h0 |-> ##[1:2] !irq)
    else $error("irq while all masked");
  seek_refuse_a: assert property (reg_write && reg_addr == atten_pos_pkg::ADDR_CTRL
    && reg_wdata[0] && reg_wdata[6] && !reg_wdata[4] && !busy |=> !step_pulse [*8])
    else $error("seek max moved without support");
  cover property (step_pulse && step_dir);
  cover property (busy && lower_limit);
  cover property ($rose(irq));
endmodule : atten_pos_props
bind atten_position_ctrl atten_pos_props u_props (.*);
`default_nettype wire

//--- sim/atten_sensor_model.sv
// Sensor model: follows the motor steps and drives the three flags.
// Assumes position 0 is the index reference; flag places are inputs so
// the bench can misadjust them.
`timescale 1ns/10ps
`default_nettype none
module atten_sensor_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic step_pulse,
  input wire logic step_dir,
  input wire logic signed [15:0] upper_at,
  input wire logic signed [15:0] lower_at,
  input wire logic signed [31:0] settle,
  input wire logic dead,
  output logic upper_limit,
  output logic lower_limit,
  output logic index_pulse
);
  logic signed [15:0] pos;
  int age;
  always @(posedge clk_sys)
  begin
    age <= (rst || step_pulse) ? 0 : age + 1;
    if (rst)
      pos <= 16'sh0;
    else if (step_pulse)
      pos <= step_dir ? pos + 16'sh1 : pos - 16'sh1;
  end
  assign upper_limit = pos <= upper_at;
  assign lower_limit = pos >= lower_at;
  // A slow index only rises once the shaft has rested for settle cycles.
  assign index_pulse = !dead && (pos % 500 == 0) && age >= settle;
endmodule : atten_sensor_model
`default_nettype wire

//--- sim/tb_attenuator_position_sensing.sv
// Bench for the attenuator position block with the sensor model beside it.
// Assumes the design package is compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin fail_count++; \
  $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module tb_attenuator_position_sensing;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata, rv;
  logic upper_limit, lower_limit, index_pulse, step_pulse, step_dir, busy, irq;
  logic signed [15:0] upper_at = -16'sd220;
  logic signed [15:0] lower_at = 16'sd8774;
  int settle = 0;
  logic dead = 1'b0;
  int fail_count = 0;
  int total_checks = 0;
  time t_last = 0;
  time last_gap = 0;
  time gap [3];
  always #5 clk_sys = ~clk_sys;
  atten_position_ctrl #(.STEP_PERIOD(10), .SETTLE_MAX(3000)) DUT (
    .clk_sys(clk_sys),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .upper_limit(upper_limit),
    .lower_limit(lower_limit),
    .index_pulse(index_pulse),
    .step_pulse(step_pulse),
    .step_dir(step_dir),
    .busy(busy),
    .irq(irq)
  );
  atten_sensor_model u_model (
    .clk_sys(clk_sys),
    .rst(rst),
    .step_pulse(step_pulse),
    .step_dir(step_dir),
    .upper_at(upper_at),
    .lower_at(lower_at),
    .settle(settle),
    .dead(dead),
    .upper_limit(upper_limit),
    .lower_limit(lower_limit),
    .index_pulse(index_pulse)
  );
  always @(posedge clk_sys)
  begin
    if (step_pulse)
    begin
      last_gap = $time - t_last;
      t_last = $time;
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    @(negedge clk_sys);
    rv = reg_rdata;
    @(posedge clk_sys);
  endtask : rd
  // Clears status first so each move is judged on its own events.
  task automatic move(input logic [15:0] t, input logic [7:0] c);
    wr(atten_pos_pkg::ADDR_STATUS, 32'hff);
    wr(atten_pos_pkg::ADDR_TARGET, {16'h0, t});
    wr(atten_pos_pkg::ADDR_CTRL, {24'h0, c});
    repeat (2) @(posedge clk_sys);
    for (int i = 0; i < 9000 && busy !== 1'b0; i++) @(posedge clk_sys);
    `CHK("busy", 1'b0, busy)
    rd(atten_pos_pkg::ADDR_STATUS);
  endtask : move
  task automatic t_reset();
    rd(atten_pos_pkg::ADDR_CTRL);
    `CHK("ctrl", 32'h20, rv)
    rd(8'h18);
    `CHK("unmapped", 32'h0, rv)
  endtask : t_reset
  task automatic t_rates();
    logic [7:0] opt [3] = '{8'h21, 8'h29, 8'h25};
    wr(atten_pos_pkg::ADDR_MASK, 32'h1);
    for (int k = 0; k < 3; k++)
    begin
      move(16'(2 * k + 2), opt[k]);
      gap[k] = last_gap;
      `CHK("done", 1'b1, rv[0])
      `CHK("irq", 1'b1, irq)
    end
    `CHK("slow", 64'd20, gap[1] - gap[0])
    `CHK("long", 64'd30, gap[2] - gap[0])
    wr(atten_pos_pkg::ADDR_MASK, 32'h0);
    @(negedge clk_sys);
    `CHK("irq masked", 1'b0, irq)
    @(posedge clk_sys);
    wr(atten_pos_pkg::ADDR_MASK, 32'h1);
    wr(atten_pos_pkg::ADDR_STATUS, 32'h1);
    repeat (2) @(negedge clk_sys);
    `CHK("irq clear", 1'b0, irq)
    @(posedge clk_sys);
  endtask : t_rates
  task automatic t_refuse();
    logic [15:0] tg [5] = '{16'hffff, 16'hff69, 16'h217f, 16'h0, 16'hfffb};
    logic [7:0] cw [5] = '{8'h21, 8'h23, 8'h23, 8'h61, 8'h23};
    int eb [5] = '{3, 3, 3, 1, 1};
    for (int k = 0; k < 5; k++)
    begin
      move(tg[k], cw[k]);
      `CHK("refused", 1'b1, rv[eb[k]])
    end
    rd(atten_pos_pkg::ADDR_POSITION);
    `CHK("pos", 32'h6, rv)
  endtask : t_refuse
  task automatic t_index();
    settle = 2100;
    move(16'h0, 8'h21);
    `CHK("slow index", 2'b11, {rv[7], rv[0]})
    settle = 0;
    move(16'h2, 8'h21);
    dead = 1'b1;
    move(16'h0, 8'h01);
    `CHK("index lost", 2'b11, {rv[6], rv[0]})
    move(16'h2, 8'h01);
    move(16'h0, 8'h21);
    `CHK("index abort", 2'b10, {rv[2], rv[0]})
    dead = 1'b0;
  endtask : t_index
  task automatic t_limits();
    lower_at = 16'sd5;
    move(16'h8, 8'h21);
    `CHK("lower", 2'b11, {rv[1], rv[5]})
    lower_at = 16'sd8774;
    upper_at = -16'sd3;
    move(16'hfffb, 8'h33);
    `CHK("upper", 2'b10, {rv[1], rv[4]})
    rd(atten_pos_pkg::ADDR_POSITION);
    `CHK("neg pos", 32'hfffffffd, rv)
    upper_at = -16'sd220;
  endtask : t_limits
  task automatic tally_and_finish();
    if (fail_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_rates();
    t_refuse();
    t_index();
    t_limits();
    tally_and_finish();
  end
  initial
  begin
    #900000;
    fail_count++;
    tally_and_finish();
  end
endmodule : tb_attenuator_position_sensing
`default_nettype wire
